// ---- rtl/pxl_link_consts.svh ----
`ifndef PXL_LINK_CONSTS_SVH
`define PXL_LINK_CONSTS_SVH

// configuration register, the only upstream address
`define PXL_CFG_ADDR 3'h0
`define PXL_CFG_RESET 16'ha601
`define PXL_CFG_VREF_HI 15
`define PXL_CFG_VREF_LO 14
`define PXL_CFG_VRST_HI 13
`define PXL_CFG_VRST_LO 12
`define PXL_CFG_OFFS_HI 11
`define PXL_CFG_OFFS_LO 10
`define PXL_CFG_GAIN_HI 9
`define PXL_CFG_GAIN_LO 8
`define PXL_CFG_ROWS_HI 7
`define PXL_CFG_ROWS_LO 0

// upstream write frame
`define PXL_UPD_CODE 4'h9
`define PXL_WR_EDGES 5'h18
`define PXL_SH_BITS 23

// downstream word and frame sequence, counts in pixel periods
`define PXL_WORD_BITS 4'hc
`define PXL_ROWS 8'hfa
`define PXL_ROW_PIX 9'h0f9
`define PXL_LAST_ROW_PIX 9'h0f8
`define PXL_SOL_WORDS 9'h003
`define PXL_EOF_WORDS 9'h004
`define PXL_CFG_WORDS 9'h1f9
`define PXL_SYNC_WORDS 9'h0f9
`define PXL_CHG_WORDS 9'h001

// half of one serial bit, in system clocks
`define PXL_HALF_BIT_CYC 8'h02

`endif

// ---- rtl/pxl_link_pkg.sv ----
package pxl_link_pkg;

   typedef enum logic [2:0] {
      PXL_PH_SOL = 3'b000,
      PXL_PH_PIX = 3'b001,
      PXL_PH_EOF = 3'b010,
      PXL_PH_CFG = 3'b011,
      PXL_PH_SYNC = 3'b100,
      PXL_PH_CHG = 3'b101
   } pxl_phase_type;

   typedef struct packed {
      pxl_phase_type phase;
      logic [7:0] hcnt;
      logic half;
      logic [3:0] bitc;
      logic [8:0] wordc;
      logic [7:0] row;
      logic [11:0] shreg;
      logic line;
      logic oe;
      logic underrun;
      logic p_meta;
      logic p_sync;
      logic n_meta;
      logic n_sync;
      logic n_prev;
      logic c_on;
      logic [4:0] ccnt;
      logic [22:0] csh;
      logic [15:0] cfg;
      logic [7:0] rst_first;
   } pxl_state_type;

endpackage

// ---- rtl/pxl_pair_buf.sv ----
`timescale 1ns/1ps
module pxl_pair_buf #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } pxl_buf_state_type;

   pxl_buf_state_type q;
   pxl_buf_state_type next_q;
   logic push;
   logic pop;

   assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o = q.mem[q.rd];

   always_comb begin
      next_q = q;
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      if (push) begin
         next_q.mem[q.wr] = in_data_i;
         next_q.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         next_q.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop) begin
         next_q.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         next_q.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// ---- rtl/pxl_link.sv ----
`timescale 1ns/1ps
`include "pxl_link_consts.svh"
// Notes on behaviour
// - downstream word: start, ten data bits, stop
// - start one, data msb first, stop zero
// - each bit xored with high-then-low data clock; EOF words held low
// - three all-zero words open every row
// - one 16-bit write-only configuration register
// - write is code, address, content; address zero
// - upstream fields are shifted msb first
// - data sampled on configuration clock rising edge
// - load register on code 1001 after 24 edges
// - clear shift register 24 edges after first high
// - rolling exposure: preceding rows held in reset
// - rows in reset bits 7:0, default 01h
// - bits 15:14 reference voltage, default 10b
// - bits 13:12 pixel reset voltage, default 10b
// - bits 11:10 ramp offset, default 01b
// - bits 9:8 inverse ramp gain, default 10b
// - link open upstream 505 pixel periods after frame
// - upstream: positive line data, negative line clock
module pxl_link
   import pxl_link_pkg::*;
#(
   parameter int PIX_W = 10,
   parameter int BUF_DEPTH = 2,
   parameter logic [7:0] HALF_BIT_CYC = `PXL_HALF_BIT_CYC,
   parameter int ROWS = `PXL_ROWS
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [PIX_W-1:0] pix_data_i,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic link_p_i,
   output logic link_p_o,
   output logic link_p_oe_o,
   input wire logic link_n_i,
   output logic link_n_o,
   output logic link_n_oe_o,
   output logic config_window_o,
   output logic pix_underrun_o,
   output logic [7:0] readout_row_o,
   output logic [7:0] reset_row_first_o,
   output logic [7:0] rows_in_reset_o,
   output logic [1:0] cds_reference_select_o,
   output logic [1:0] pixel_reset_voltage_select_o,
   output logic [1:0] ramp_offset_select_o,
   output logic [1:0] inverse_gain_select_o
);

   pxl_state_type q;
   pxl_state_type next_q;

   logic [PIX_W-1:0] buf_data;
   logic buf_valid;
   logic buf_pop;
   logic half_en;
   logic word_done;
   logic phase_end;
   logic scl_rise;
   logic [8:0] phase_len;

   // the serializer cannot pause, so the buffer absorbs source jitter
   pxl_pair_buf #(
      .WIDTH(PIX_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .in_data_i(pix_data_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .out_data_o(buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(buf_pop)
   );

   function automatic logic [8:0] words_in_phase(input pxl_phase_type ph, input logic [7:0] row);
      logic [8:0] len;
      len = `PXL_CHG_WORDS;
      unique case (ph)
         PXL_PH_SOL: len = `PXL_SOL_WORDS;
         PXL_PH_PIX: len = (row == 8'(ROWS - 1)) ? `PXL_LAST_ROW_PIX : `PXL_ROW_PIX;
         PXL_PH_EOF: len = `PXL_EOF_WORDS;
         PXL_PH_CFG: len = `PXL_CFG_WORDS;
         PXL_PH_SYNC: len = `PXL_SYNC_WORDS;
         PXL_PH_CHG: len = `PXL_CHG_WORDS;
         default: len = `PXL_CHG_WORDS;
      endcase
      return len;
   endfunction

   always_comb begin
      next_q = q;
      buf_pop = 1'b0;
      half_en = (q.hcnt == HALF_BIT_CYC - 8'h01);
      word_done = half_en && q.half && (q.bitc == `PXL_WORD_BITS - 4'h1);
      phase_len = words_in_phase(q.phase, q.row);
      phase_end = word_done && (q.wordc == phase_len - 9'h001);

      // pins pass two flops before anything looks at them
      next_q.p_meta = link_p_i;
      next_q.p_sync = q.p_meta;
      next_q.n_meta = link_n_i;
      next_q.n_sync = q.n_meta;
      next_q.n_prev = q.n_sync;
      scl_rise = q.n_sync && !q.n_prev && (q.phase == PXL_PH_CFG);

      // half-bit enable divider
      next_q.hcnt = half_en ? 8'h00 : q.hcnt + 8'h01;

      // line is held low in EOF and CFG, else bit xor data clock; clock is high in the first half
      if (q.phase == PXL_PH_EOF || q.phase == PXL_PH_CFG) begin
         next_q.line = 1'b0;
      end else begin
         next_q.line = q.shreg[11] ^ !q.half;
      end

      if (half_en) begin
         next_q.half = !q.half;
         if (q.half) begin
            if (word_done) begin
               next_q.bitc = 4'h0;
            end else begin
               next_q.bitc = q.bitc + 4'h1;
               next_q.shreg = {q.shreg[10:0], 1'b0};
            end
         end
      end

      if (word_done) begin
         next_q.wordc = q.wordc + 9'h001;
         if (phase_end) begin
            next_q.wordc = 9'h000;
            unique case (q.phase)
               PXL_PH_SOL: next_q.phase = PXL_PH_PIX;
               PXL_PH_PIX: begin
                  if (q.row == 8'(ROWS - 1)) begin
                     next_q.phase = PXL_PH_EOF;
                  end else begin
                     next_q.phase = PXL_PH_SOL;
                     next_q.row = q.row + 8'h01;
                  end
               end
               PXL_PH_EOF: next_q.phase = PXL_PH_CFG;
               PXL_PH_CFG: next_q.phase = PXL_PH_SYNC;
               PXL_PH_SYNC: next_q.phase = PXL_PH_CHG;
               PXL_PH_CHG: begin
                  next_q.phase = PXL_PH_SOL;
                  next_q.row = 8'h00;
               end
               default: next_q.phase = PXL_PH_SOL;
            endcase
         end
         // load the next word; only pixel words carry data
         next_q.shreg = 12'h000;
         if (next_q.phase == PXL_PH_PIX) begin
            buf_pop = buf_valid;
            next_q.underrun = !buf_valid;
            next_q.shreg = {1'b1, buf_valid ? buf_data : {PIX_W{1'b0}}, 1'b0};
         end
      end

      // pins are released only while the upstream window is open
      next_q.oe = (next_q.phase != PXL_PH_CFG);

      // upstream configuration write
      if (q.phase != PXL_PH_CFG) begin
         next_q.c_on = 1'b0;
         next_q.ccnt = 5'h00;
         next_q.csh = '0;
      end else if (scl_rise) begin
         if (!q.c_on) begin
            if (q.p_sync) begin
               next_q.c_on = 1'b1;
               next_q.ccnt = 5'h01;
               next_q.csh = {22'h0, 1'b1};
            end
         end else if (q.ccnt == `PXL_WR_EDGES - 5'h01) begin
            if (q.csh[22:19] == `PXL_UPD_CODE && q.csh[18:16] == `PXL_CFG_ADDR) begin
               next_q.cfg = q.csh[15:0];
            end
            next_q.c_on = 1'b0;
            next_q.ccnt = 5'h00;
            next_q.csh = '0;
         end else begin
            next_q.ccnt = q.ccnt + 5'h01;
            next_q.csh = {q.csh[21:0], q.p_sync};
         end
      end

      // first of the rows held in reset ahead of the readout row
      if (q.row >= q.cfg[`PXL_CFG_ROWS_HI:`PXL_CFG_ROWS_LO]) begin
         next_q.rst_first = q.row - q.cfg[`PXL_CFG_ROWS_HI:`PXL_CFG_ROWS_LO];
      end else begin
         next_q.rst_first = 8'(q.row + 8'(ROWS) - q.cfg[`PXL_CFG_ROWS_HI:`PXL_CFG_ROWS_LO]);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.phase <= PXL_PH_SOL;
         q.oe <= 1'b1;
         q.cfg <= `PXL_CFG_RESET;
      end else begin
         q <= next_q;
      end
   end

   // negative line is the complement while driving
   assign link_p_o = q.line;
   assign link_n_o = !q.line;
   assign link_p_oe_o = q.oe;
   assign link_n_oe_o = q.oe;
   assign config_window_o = !q.oe;
   assign pix_underrun_o = q.underrun;
   assign readout_row_o = q.row;
   assign reset_row_first_o = q.rst_first;
   // values 249 to 255 are passed on unchecked; software must avoid them
   assign rows_in_reset_o = q.cfg[`PXL_CFG_ROWS_HI:`PXL_CFG_ROWS_LO];
   assign cds_reference_select_o = q.cfg[`PXL_CFG_VREF_HI:`PXL_CFG_VREF_LO];
   assign pixel_reset_voltage_select_o = q.cfg[`PXL_CFG_VRST_HI:`PXL_CFG_VRST_LO];
   assign ramp_offset_select_o = q.cfg[`PXL_CFG_OFFS_HI:`PXL_CFG_OFFS_LO];
   assign inverse_gain_select_o = q.cfg[`PXL_CFG_GAIN_HI:`PXL_CFG_GAIN_LO];
endmodule

// ---- verif/pxl_link_sva.sv ----
`timescale 1ns/1ps
module pxl_link_sva #(
   parameter logic [7:0] HALF_BIT_CYC = 8'h02,
   parameter int ROWS = 250
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic pix_valid_i,
   input wire logic pix_ready_o,
   input wire logic link_p_o,
   input wire logic link_n_o,
   input wire logic link_p_oe_o,
   input wire logic link_n_oe_o,
   input wire logic config_window_o,
   input wire logic pix_underrun_o,
   input wire logic [7:0] readout_row_o,
   input wire logic [7:0] reset_row_first_o,
   input wire logic [7:0] rows_in_reset_o,
   input wire logic [1:0] inverse_gain_select_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   logic [15:0] wcnt;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i)
         wcnt <= 16'h0000;
      else
         wcnt <= config_window_o ? wcnt + 16'h0001 : 16'h0000;
   end
   AST_N_INV: assert property (link_p_oe_o |-> link_n_o != link_p_o)
      else $error("negative line is not the inverse");
   AST_OE_PAIR: assert property (
      link_n_oe_o == link_p_oe_o && config_window_o != link_p_oe_o)
      else $error("drive enables disagree");
   AST_WIN_LEN: assert property (
      $fell(config_window_o) |-> wcnt == 16'h01f9 * 16'h0018 * HALF_BIT_CYC)
      else $error("upstream window length wrong");
   AST_CFG_HOLD: assert property (
      !config_window_o && !$past(config_window_o)
      |-> $stable(rows_in_reset_o) && $stable(inverse_gain_select_o))
      else $error("configuration changed outside window");
   AST_ROW_MAX: assert property (readout_row_o < 8'(ROWS))
      else $error("row out of range");
   AST_RST_FIRST: assert property (
      $past(rst_b_i) |-> reset_row_first_o == 8'(({1'b0, $past(readout_row_o)}
      + 9'(ROWS) - {1'b0, $past(rows_in_reset_o)}) % 9'(ROWS)))
      else $error("reset row wrong");
   AST_READY_FALL: assert property ($fell(pix_ready_o) |-> $past(pix_valid_i))
      else $error("buffer filled without a push");
   // a push in the load cycle itself is legal, so look one cycle further back
   AST_UNDERRUN: assert property ($rose(pix_underrun_o) |-> !$past(pix_valid_i, 2))
      else $error("underrun while pixels offered");
endmodule
bind pxl_link pxl_link_sva #(.HALF_BIT_CYC(HALF_BIT_CYC), .ROWS(ROWS)) u_sva (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pix_valid_i(pix_valid_i),
   .pix_ready_o(pix_ready_o), .link_p_o(link_p_o), .link_n_o(link_n_o),
   .link_p_oe_o(link_p_oe_o), .link_n_oe_o(link_n_oe_o),
   .config_window_o(config_window_o), .pix_underrun_o(pix_underrun_o),
   .readout_row_o(readout_row_o), .reset_row_first_o(reset_row_first_o),
   .rows_in_reset_o(rows_in_reset_o), .inverse_gain_select_o(inverse_gain_select_o));

// ---- verif/pxl_prox_model.sv ----
`timescale 1ns/1ps
module pxl_prox_model (
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire logic [22:0] frame_i,
   output logic p_o,
   output logic n_o,
   output logic busy_o
);
   initial begin
      p_o = 1'b0;
      n_o = 1'b0;
      busy_o = 1'b0;
   end
   // 8 clocks a half period, faster than 2.5 MHz to keep the window short;
   // the receiver needs only three clocks a level; lines stay driven against pickup
   always @(posedge clk_sys_i) begin
      if (go_i && !busy_o) begin
         busy_o <= 1'b1;
         for (int k = 0; k < 24; k++) begin
            repeat (8) @(posedge clk_sys_i);
            n_o <= 1'b0;
            p_o <= (k < 23) ? frame_i[22 - k] : 1'b0;
            repeat (8) @(posedge clk_sys_i);
            n_o <= 1'b1;
         end
         repeat (8) @(posedge clk_sys_i);
         n_o <= 1'b0;
         busy_o <= 1'b0;
      end
   end
endmodule

// ---- verif/test_pxl_link.sv ----
`timescale 1ns/1ps
module test_pxl_link;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [9:0] pix_data_i = 10'h3ff;
   logic pix_valid_i = 1'b1;
   logic pix_ready_o, link_p_o, link_p_oe_o, link_n_o, link_n_oe_o, win, und, a;
   logic [7:0] row, rows;
   logic [1:0] cds, vrst, offs, gain;
   logic wp, wn, m_p, m_n, busy, go = 1'b0, feed = 1'b1;
   logic [22:0] frame = 23'h000000;
   logic [15:0] lf = 16'h0009, d, e;
   logic [6:0] hd;
   logic [11:0] w;
   logic [9:0] q[$];
   int n_fail = 0, checks = 0, nacc = 0, t;
   // a short frame keeps the run small; the row count and the half-bit length differ
   localparam int ROWS = 4;
   always #5 clk_sys_i = ~clk_sys_i;
   assign wp = link_p_oe_o ? link_p_o : m_p;
   assign wn = link_n_oe_o ? link_n_o : m_n;
   pxl_link #(.HALF_BIT_CYC(8'h01), .ROWS(ROWS)) dut (.clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .pix_data_i(pix_data_i), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
      .link_p_i(wp), .link_p_o(link_p_o), .link_p_oe_o(link_p_oe_o), .link_n_i(wn),
      .link_n_o(link_n_o), .link_n_oe_o(link_n_oe_o), .config_window_o(win),
      .pix_underrun_o(und), .readout_row_o(row), .reset_row_first_o(),
      .rows_in_reset_o(rows), .cds_reference_select_o(cds),
      .pixel_reset_voltage_select_o(vrst), .ramp_offset_select_o(offs),
      .inverse_gain_select_o(gain));
   pxl_prox_model prox (.clk_sys_i(clk_sys_i), .go_i(go), .frame_i(frame), .p_o(m_p),
      .n_o(m_n), .busy_o(busy));
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [11:0] mk(logic [9:0] v);
      logic [11:0] r;
      r = 12'h001;
      for (int i = 0; i < 10; i++)
         r[1 + i] = v[9 - i];
      return r;
   endfunction
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tmo();
      n_fail++;
      print_verdict();
   endtask
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask
   // in step with the serializer: one look per half bit stands in for oversampling
   task automatic rd();
      for (int b = 0; b < 12; b++) begin
         a = link_p_o;
         tick();
         w[b] = link_p_o;
         chk(a, !w[b]);
         tick();
      end
   endtask
   task automatic wr(logic [22:0] f);
      frame = f;
      go = 1'b1;
      for (t = 0; busy !== 1'b1 && t < 50; t++) tick();
      if (t >= 50) tmo();
      go = 1'b0;
      for (t = 0; busy !== 1'b0 && t < 1000; t++) tick();
      if (t >= 1000) tmo();
      repeat (8) tick();
   endtask
   // a refused word is held until taken
   always @(posedge clk_sys_i) begin
      if (rst_b_i && pix_valid_i && pix_ready_o) begin
         q.push_back(pix_data_i);
         nacc++;
         lf = nxt(lf);
         #1;
         pix_data_i = (nacc == 1) ? 10'h18d : lf[9:0];
      end else
         #1;
      pix_valid_i = feed;
   end
   initial begin
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk({cds, vrst, offs, gain, rows}, 16'ha601);
      chk({link_p_o, link_n_o, link_p_oe_o, win}, 4'b0110);
      rst_b_i = 1'b1;
      for (t = 0; link_p_o !== 1'b1 && t < 20; t++) tick();
      if (t >= 20) tmo();
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 3; i++) begin
            rd();
            chk(w, 12'h000);
         end
         for (int i = 0; i < ((r < 2) ? 249 : 5); i++) begin
            rd();
            if (i == 5) chk(row, 16'(r));
            if (q.size() == 0) begin
               chk(und, 1'b1);
               chk(w, 12'h001);
            end else
               chk(w, mk(q.pop_front()));
            if (r == 1 && i == 200) feed = 1'b0;
         end
         feed = 1'b1;
      end
      for (t = 0; win !== 1'b1 && t < 20000; t++) tick();
      if (t >= 20000) tmo();
      chk(link_p_oe_o, 1'b0);
      e = 16'ha601;
      for (int k = 0; k < 4; k++) begin
         lf = nxt(lf);
         // rows stay below the shortened frame; the corner is its largest legal value
         d = {lf[15:14], 1'b0, lf[12:8], 8'(lf[7:0] % 8'(ROWS - 1))};
         if (k == 0) d = {8'h1d, 8'(ROWS - 2)};
         hd = (k == 1) ? 7'h58 : ((k == 2) ? 7'h49 : 7'h48);
         wr({hd, d});
         if (hd == 7'h48) e = d;
         chk({cds, vrst, offs, gain, rows}, e);
      end
      for (t = 0; win !== 1'b0 && t < 20000; t++) tick();
      if (t >= 20000) tmo();
      chk(link_p_oe_o, 1'b1);
      print_verdict();
   end
endmodule
